// >>> flash_read_consts.vh
/*
  Shared constants of the serial flash read controller: idle-line codes,
  FIFO shape and frame layout.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef FLASH_READ_CONSTS_VH
`define FLASH_READ_CONSTS_VH

// ----------------------------------------
// Idle value codes per data line
// ----------------------------------------
`define IDLE_LOW 2'h0
`define IDLE_HIGH 2'h1
`define IDLE_HOLD 2'h2
`define IDLE_FLOAT 2'h3

// ----------------------------------------
// Data buffer and frame layout
// ----------------------------------------
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define FIFO_ROOM_MAX 5'h0c
`define CMD_CYCLES 7'h08
`define ADDR3_CYCLES_X1 7'h18
`define ADDR4_CYCLES_X1 7'h20
`define ADDR3_CYCLES_X4 7'h06
`define ADDR4_CYCLES_X4 7'h08
`define DATA_CYCLES_X1 7'h20
`define DATA_CYCLES_X4 7'h08
`define BYTE_BITS_X1 3'h7
`define BYTE_NIBBLES_X4 3'h1

`endif

// >>> read_data_fifo.v
/*
  Synchronous FIFO with a registered output stage.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_consts.vh"

module read_data_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_b_i,
  // Fill side
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  output wire [AW:0] level_o,
  // Drain side
  output wire out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] cnt_q;
  reg out_valid_q;
  reg [WIDTH-1:0] out_data_q;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign push = in_valid_i && in_ready_o;
  // Refill the output register whenever it is empty or being taken
  assign pop = (cnt_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready_i);
  assign level_o = cnt_q;
  assign out_valid_o = out_valid_q;
  assign out_data_o = out_data_q;

  always @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_data_q <= mem_q[rd_ptr_q];
        out_valid_q <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_q <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// >>> serial_flash_bus_controller.v
/*
  Memory-mapped serial flash read engine: one 32-bit word per request,
  with programmable select/clock delays, rate, phases and idle lines.
  Assumes settings come from logic on core_clk_i and stay put while busy;
  data lines arrive from pins and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_consts.vh"

module serial_flash_bus_controller (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_b_i,
  // Read request from the mapped window
  input wire req_valid_i,
  input wire [31:0] req_addr_i,
  output wire req_ready_o,
  // Read data, four bytes per request, lowest address first
  output wire [7:0] rd_data_o,
  output wire rd_valid_o,
  input wire rd_ready_i,
  // Settings
  input wire [2:0] next_access_delay_i,
  input wire [2:0] select_negate_delay_i,
  input wire [2:0] clock_start_delay_i,
  input wire [7:0] rate_value_i,
  input wire [1:0] rate_divider_select_i,
  input wire clock_polarity_i,
  input wire transmit_phase_i,
  input wire receive_sample_phase_i,
  input wire [1:0] line0_idle_value_i,
  input wire [1:0] line1_idle_value_i,
  input wire [1:0] line2_idle_value_i,
  input wire [1:0] line3_idle_value_i,
  input wire quad_width_i,
  input wire addr_4byte_i,
  input wire [7:0] read_command_i,
  input wire [4:0] dummy_cycles_i,
  // Status
  output wire busy_o,
  // Flash pins
  output wire flash_chip_select_b_o,
  output wire serial_clock_o,
  output wire [3:0] data_line_o,
  output wire [3:0] data_line_oe_o,
  input wire [3:0] data_line_i
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_LEAD = 3'h1;
  localparam [2:0] S_XFER = 3'h2;
  localparam [2:0] S_TRAIL = 3'h3;
  localparam [2:0] S_GAP = 3'h4;

  reg [2:0] st_q;
  reg req_ready_q;
  reg cs_b_q;
  reg sclk_q;
  reg phase_q;
  reg [10:0] hc_q;
  reg [10:0] half_q;
  reg [4:0] dly_q;
  reg [6:0] cyc_q;
  reg [39:0] tx_q;
  reg [7:0] rx_q;
  reg [2:0] rxn_q;
  reg [1:0] rx_pipe_q;
  reg push_q;
  reg [7:0] push_data_q;
  reg [3:0] din_s1_q;
  reg [3:0] din_s2_q;
  reg [3:0] dout_q;
  reg [3:0] oe_q;
  reg quad_q, a4_q, cpol_q, transmit_phase_q, receive_sample_phase_q;
  reg [2:0] nad_q, snd_q;
  reg [4:0] dummy_q;

  wire fifo_in_ready;
  wire [4:0] fifo_level;
  wire room = fifo_in_ready && (fifo_level <= `FIFO_ROOM_MAX);
  wire take = req_valid_i && req_ready_q;
  wire tick = (hc_q == 11'h000);

  // ----------------------------------------
  // Serial clock rate
  // ----------------------------------------
  // Half period in bus cycles; rate 0 halves the divider, floor of one cycle
  reg [10:0] half_w;
  always @* begin
    if (rate_value_i == 8'h00) begin
      half_w = (rate_divider_select_i == 2'h0) ? 11'h001 :
               (11'h001 << (rate_divider_select_i - 2'h1));
    end else begin
      half_w = {3'h0, rate_value_i} << rate_divider_select_i;
    end
  end

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  wire [6:0] e_addr = `CMD_CYCLES + (quad_q ? (a4_q ? `ADDR4_CYCLES_X4 : `ADDR3_CYCLES_X4) :
                      (a4_q ? `ADDR4_CYCLES_X1 : `ADDR3_CYCLES_X1));
  wire [6:0] e_dummy = e_addr + {2'h0, dummy_q};
  wire [6:0] e_last = e_dummy + (quad_q ? `DATA_CYCLES_X4 : `DATA_CYCLES_X1) - 7'h01;

  wire lead_ev = tick && ((st_q == S_LEAD && dly_q == 5'h00) || (st_q == S_XFER && !phase_q));
  wire trail_ev = tick && (st_q == S_XFER) && phase_q;
  // Trailing-edge launch presets the first bit half a period before the first edge
  wire pre_ev = tick && (st_q == S_LEAD) && (dly_q == 5'h01);
  wire tx_ev = transmit_phase_q ? lead_ev : (trail_ev || pre_ev);
  wire rx_ev = receive_sample_phase_q ? trail_ev : lead_ev;
  wire [6:0] ncyc = transmit_phase_q ? cyc_q : (cyc_q + 7'h01);

  // ----------------------------------------
  // Transmit line values for the next cycle
  // ----------------------------------------
  reg [3:0] tx_d_w;
  reg [3:0] tx_oe_w;
  reg [39:0] tx_next_w;
  always @* begin
    tx_next_w = tx_q;
    tx_d_w = {2'h3, dout_q[1], tx_q[39]};
    tx_oe_w = 4'hd;
    if (ncyc < `CMD_CYCLES) begin
      tx_next_w = {tx_q[38:0], 1'b0};
    end else if (ncyc < e_addr && quad_q) begin
      tx_d_w = tx_q[39:36];
      tx_oe_w = 4'hf;
      tx_next_w = {tx_q[35:0], 4'h0};
    end else if (ncyc < e_addr) begin
      tx_next_w = {tx_q[38:0], 1'b0};
    end else begin
      // Dummy and data cycles: the flash drives; quad releases all lines, single width releases line 1 only
      tx_d_w = dout_q;
      tx_oe_w = quad_q ? 4'h0 : 4'hd;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= S_IDLE;
      req_ready_q <= 1'b0;
      cs_b_q <= 1'b1;
      sclk_q <= 1'b0;
      phase_q <= 1'b0;
      hc_q <= 11'h000;
      half_q <= 11'h001;
      dly_q <= 5'h00;
      cyc_q <= 7'h00;
      tx_q <= 40'h0000000000;
      quad_q <= 1'b0;
      a4_q <= 1'b0;
      cpol_q <= 1'b0;
      transmit_phase_q <= 1'b0;
      receive_sample_phase_q <= 1'b0;
      nad_q <= 3'h0;
      snd_q <= 3'h0;
      dummy_q <= 5'h00;
    end else begin
      hc_q <= tick ? (half_q - 11'h001) : (hc_q - 11'h001);
      req_ready_q <= (st_q == S_IDLE) && !take && room;
      case (st_q)
        S_IDLE: begin
          sclk_q <= clock_polarity_i;
          if (take) begin
            // Settings are captured so a change mid-access has no effect
            quad_q <= quad_width_i;
            a4_q <= addr_4byte_i;
            cpol_q <= clock_polarity_i;
            transmit_phase_q <= transmit_phase_i;
            receive_sample_phase_q <= receive_sample_phase_i;
            nad_q <= next_access_delay_i;
            snd_q <= select_negate_delay_i;
            dummy_q <= dummy_cycles_i;
            half_q <= half_w;
            hc_q <= half_w - 11'h001;
            tx_q <= addr_4byte_i ? {read_command_i, req_addr_i} :
                    {read_command_i, req_addr_i[23:0], 8'h00};
            cs_b_q <= 1'b0;
            dly_q <= {1'b0, clock_start_delay_i, 1'b1};
            cyc_q <= 7'h00;
            phase_q <= 1'b0;
            st_q <= S_LEAD;
          end
        end
        S_LEAD: begin
          if (tick && dly_q == 5'h00) begin
            sclk_q <= ~cpol_q;
            phase_q <= 1'b1;
            st_q <= S_XFER;
          end else if (tick) begin
            dly_q <= dly_q - 5'h01;
          end
        end
        S_XFER: begin
          if (lead_ev) begin
            sclk_q <= ~cpol_q;
            phase_q <= 1'b1;
          end
          if (trail_ev) begin
            sclk_q <= cpol_q;
            phase_q <= 1'b0;
            cyc_q <= cyc_q + 7'h01;
            if (cyc_q == e_last) begin
              dly_q <= {1'b0, snd_q, 1'b0} + 5'h02;
              st_q <= S_TRAIL;
            end
          end
        end
        S_TRAIL: begin
          if (tick && dly_q == 5'h00) begin
            cs_b_q <= 1'b1;
            dly_q <= {1'b0, nad_q, 1'b1};
            st_q <= S_GAP;
          end else if (tick) begin
            dly_q <= dly_q - 5'h01;
          end
        end
        S_GAP: begin
          if (tick && dly_q == 5'h00) begin
            st_q <= S_IDLE;
          end else if (tick) begin
            dly_q <= dly_q - 5'h01;
          end
        end
        default: begin
          st_q <= S_IDLE;
          cs_b_q <= 1'b1;
        end
      endcase
      if (tx_ev) begin
        tx_q <= tx_next_w;
      end
    end
  end

  // ----------------------------------------
  // Data lines: drive and idle values
  // ----------------------------------------
  wire [7:0] idle_code = {line3_idle_value_i, line2_idle_value_i, line1_idle_value_i, line0_idle_value_i};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_line
      always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          dout_q[gi] <= 1'b0;
          oe_q[gi] <= 1'b0;
        end else if (cs_b_q) begin
          case (idle_code[2*gi+1:2*gi])
            `IDLE_LOW: begin
              dout_q[gi] <= 1'b0;
              oe_q[gi] <= 1'b1;
            end
            `IDLE_HIGH: begin
              dout_q[gi] <= 1'b1;
              oe_q[gi] <= 1'b1;
            end
            `IDLE_HOLD: begin
              oe_q[gi] <= 1'b1;
            end
            default: begin
              oe_q[gi] <= 1'b0;
            end
          endcase
        end else if (tx_ev) begin
          dout_q[gi] <= tx_d_w[gi];
          oe_q[gi] <= tx_oe_w[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  // Strobe delayed two cycles so it meets the pin value seen at the edge
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      din_s1_q <= 4'h0;
      din_s2_q <= 4'h0;
      rx_q <= 8'h00;
      rxn_q <= 3'h0;
      rx_pipe_q <= 2'h0;
      push_q <= 1'b0;
      push_data_q <= 8'h00;
    end else begin
      din_s1_q <= data_line_i;
      din_s2_q <= din_s1_q;
      push_q <= 1'b0;
      rx_pipe_q <= {rx_pipe_q[0], rx_ev && (cyc_q >= e_dummy) && (cyc_q <= e_last)};
      if (st_q == S_IDLE) begin
        rxn_q <= 3'h0;
      end else if (rx_pipe_q[1]) begin
        if (quad_q) begin
          rx_q <= {rx_q[3:0], din_s2_q};
          if (rxn_q == `BYTE_NIBBLES_X4) begin
            push_q <= 1'b1;
            push_data_q <= {rx_q[3:0], din_s2_q};
            rxn_q <= 3'h0;
          end else begin
            rxn_q <= rxn_q + 3'h1;
          end
        end else begin
          rx_q <= {rx_q[6:0], din_s2_q[1]};
          if (rxn_q == `BYTE_BITS_X1) begin
            push_q <= 1'b1;
            push_data_q <= {rx_q[6:0], din_s2_q[1]};
          end
          rxn_q <= rxn_q + 3'h1;
        end
      end
    end
  end

  read_data_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(push_q),
    .in_data_i(push_data_q),
    .in_ready_o(fifo_in_ready),
    .level_o(fifo_level),
    .out_valid_o(rd_valid_o),
    .out_data_o(rd_data_o),
    .out_ready_i(rd_ready_i)
  );

  assign req_ready_o = req_ready_q;
  assign busy_o = (st_q != S_IDLE);
  assign flash_chip_select_b_o = cs_b_q;
  assign serial_clock_o = sclk_q;
  assign data_line_o = dout_q;
  assign data_line_oe_o = oe_q;
endmodule
`default_nettype wire

// >>> serial_flash_bus_controller_assertions.sv
/*
  Concurrent checks on the serial flash read controller's ports.
  Assumes settings are held steady while an access runs.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_checker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Request and read data
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic rd_ready_i,
  // Settings
  input wire logic [2:0] next_access_delay_i,
  input wire logic [2:0] select_negate_delay_i,
  input wire logic [2:0] clock_start_delay_i,
  input wire logic [7:0] rate_value_i,
  input wire logic [1:0] rate_divider_select_i,
  input wire logic clock_polarity_i,
  input wire logic [1:0] line0_idle_value_i,
  input wire logic [1:0] line3_idle_value_i,
  // Status and pins
  input wire logic busy_o,
  input wire logic flash_chip_select_b_o,
  input wire logic serial_clock_o,
  input wire logic [3:0] data_line_o,
  input wire logic [3:0] data_line_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // Edge spacing counters
  // ----------------------------------------
  int half, cnt_q, gap_q, lead, neg;
  logic seen_q;
  always_comb begin
    if (rate_value_i == 8'h00)
      half = (rate_divider_select_i == 2'h0) ? 1 : (1 << (rate_divider_select_i - 1));
    else
      half = int'(rate_value_i) << rate_divider_select_i;
    lead = 2 * (clock_start_delay_i + 1) * half;
    neg = (2 * select_negate_delay_i + 3) * half;
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 0;
      gap_q <= 100000;
      seen_q <= 1'b0;
    end else begin
      cnt_q <= ($changed(serial_clock_o) || $fell(flash_chip_select_b_o)) ? 1 : cnt_q + 1;
      gap_q <= $rose(flash_chip_select_b_o) ? 1 : gap_q + 1;
      if ($fell(flash_chip_select_b_o))
        seen_q <= 1'b0;
      else if ($changed(serial_clock_o) && !flash_chip_select_b_o)
        seen_q <= 1'b1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_take_starts_frame: assert property (req_valid_i && req_ready_o |=>
    !req_ready_o && busy_o && !flash_chip_select_b_o) else $error("request take did not start a frame");
  a_busy_blocks_req: assert property (busy_o |-> !req_ready_o)
    else $error("ready while busy");
  a_lead_delay: assert property ($changed(serial_clock_o) && !flash_chip_select_b_o && !seen_q
    |-> cnt_q >= lead - 1 && cnt_q <= lead + 1) else $error("clock start delay wrong");
  a_negate_delay: assert property ($rose(flash_chip_select_b_o)
    |-> cnt_q >= neg - 1 && cnt_q <= neg + 1) else $error("select negate delay wrong");
  a_next_gap: assert property ($fell(flash_chip_select_b_o)
    |-> gap_q >= 2 * (next_access_delay_i + 1) * half) else $error("next access gap too short");
  a_half_period: assert property ($changed(serial_clock_o) && !flash_chip_select_b_o && seen_q
    |-> cnt_q == half) else $error("serial clock half period wrong");
  a_idle_float: assert property (!busy_o && !$past(busy_o) && $past(line0_idle_value_i) == 2'h3
    |-> !data_line_oe_o[0]) else $error("idle line not released");
  a_idle_drive_high: assert property (!busy_o && !$past(busy_o) && $past(rst_b_i)
    && $past(line3_idle_value_i) == 2'h1 |-> data_line_oe_o[3] && data_line_o[3])
    else $error("idle line not driven high");
  a_read_hold: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o))
    else $error("read byte dropped before taken");
  a_sclk_rest: assert property (flash_chip_select_b_o && !busy_o
    |-> serial_clock_o == clock_polarity_i) else $error("serial clock not at rest level");
endmodule

bind serial_flash_bus_controller flash_ctrl_checker chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
  .next_access_delay_i(next_access_delay_i), .select_negate_delay_i(select_negate_delay_i),
  .clock_start_delay_i(clock_start_delay_i), .rate_value_i(rate_value_i),
  .rate_divider_select_i(rate_divider_select_i), .clock_polarity_i(clock_polarity_i),
  .line0_idle_value_i(line0_idle_value_i), .line3_idle_value_i(line3_idle_value_i), .busy_o(busy_o),
  .flash_chip_select_b_o(flash_chip_select_b_o), .serial_clock_o(serial_clock_o),
  .data_line_o(data_line_o), .data_line_oe_o(data_line_oe_o));
`default_nettype wire

// >>> flash_model.sv
/*
  Behavioural serial flash: takes command and address, returns one word
  made from the address. Assumes clock polarity 0 and a flash already set
  up for the width, address size and dummy count it is told.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  // Flash pins
  input wire logic cs_b_i,
  input wire logic sclk_i,
  input wire logic [3:0] line_i,
  output logic [3:0] d_o,
  output logic [3:0] oe_o,
  // Setup the flash was given
  input wire logic quad_i,
  input wire logic addr4_i,
  input wire logic [4:0] dummy_i,
  output logic [7:0] cmd_o
);
  int n, ac;
  logic [31:0] addr_q, word_q;
  function automatic logic [7:0] fb(input logic [31:0] a);
    return a[7:0] ^ a[31:24] ^ 8'h5a;
  endfunction
  initial begin
    oe_o = 4'h0;
    d_o = 4'h0;
  end
  always_comb ac = quad_i ? (addr4_i ? 8 : 6) : (addr4_i ? 32 : 24);
  always @(negedge cs_b_i) begin
    n = 0;
    addr_q = 32'h0;
  end
  // Lines let go as soon as select is released
  always @(posedge cs_b_i) oe_o = 4'h0;
  always @(posedge sclk_i) begin
    if (!cs_b_i) begin
      if (n < 8)
        cmd_o = {cmd_o[6:0], line_i[0]};
      else if (n < 8 + ac)
        addr_q = quad_i ? {addr_q[27:0], line_i} : {addr_q[30:0], line_i[0]};
      n = n + 1;
    end
  end
  always @(negedge sclk_i) begin
    if (!cs_b_i && n >= 8 + ac + dummy_i) begin
      if (n == 8 + ac + dummy_i)
        word_q = {fb(addr_q), fb(addr_q + 1), fb(addr_q + 2), fb(addr_q + 3)};
      oe_o = quad_i ? 4'hf : 4'h2;
      d_o = quad_i ? word_q[31:28] : {2'h0, word_q[31], 1'h0};
      word_q = quad_i ? word_q << 4 : word_q << 1;
    end
  end
endmodule
`default_nettype wire

// >>> test_serial_flash_bus_controller.sv
/*
  Self-checking bench for the serial flash read controller with a flash
  model behind its pins. Assumes the controller is the only top design.
*/
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_bus_controller;
  logic core_clk_i, rst_b_i, req_valid_i, rd_ready_i, fill, quad, a4, rxph;
  logic [31:0] req_addr_i;
  logic [2:0] dly;
  logic [7:0] rate, cmd, idle;
  logic [1:0] div;
  logic [4:0] dummy;
  wire logic [7:0] rd_data_o, fl_cmd;
  wire logic rd_valid_o, req_ready_o, busy_o, cs_b, sclk;
  wire logic [3:0] dq_o, dq_oe, fl_d, fl_oe, pins;
  int miscompares, cmp_count, j;
  // Unowned lines wander so a stale value never reads back
  assign pins = (dq_oe & dq_o) | (~dq_oe & fl_oe & fl_d) | (~dq_oe & ~fl_oe & {fill, ~fill, fill, ~fill});
  serial_flash_bus_controller DUT (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_addr_i(req_addr_i),
    .req_ready_o(req_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
    .next_access_delay_i(dly), .select_negate_delay_i(dly), .clock_start_delay_i(dly),
    .rate_value_i(rate), .rate_divider_select_i(div), .clock_polarity_i(1'b0), .transmit_phase_i(1'b0),
    .receive_sample_phase_i(rxph), .line0_idle_value_i(idle[1:0]), .line1_idle_value_i(idle[3:2]),
    .line2_idle_value_i(idle[5:4]), .line3_idle_value_i(idle[7:6]), .quad_width_i(quad),
    .addr_4byte_i(a4), .read_command_i(cmd), .dummy_cycles_i(dummy), .busy_o(busy_o),
    .flash_chip_select_b_o(cs_b), .serial_clock_o(sclk), .data_line_o(dq_o), .data_line_oe_o(dq_oe),
    .data_line_i(pins));
  flash_model fl (.cs_b_i(cs_b), .sclk_i(sclk), .line_i(pins), .d_o(fl_d), .oe_o(fl_oe),
    .quad_i(quad), .addr4_i(a4), .dummy_i(dummy), .cmd_o(fl_cmd));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) fill <= ~fill;
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  function automatic logic [7:0] fb(input logic [31:0] a);
    logic [31:0] b;
    b = a4 ? a : {8'h00, a[23:0]};
    return b[7:0] ^ b[31:24] ^ 8'h5a;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic [2:0] d, input logic [7:0] r, input logic [1:0] v, input logic ph,
    input logic q, input logic x, input logic [7:0] c, input logic [4:0] dm, input logic [7:0] il);
    @(posedge core_clk_i);
    #1 dly = d;
    rate = r;
    div = v;
    rxph = ph;
    quad = q;
    a4 = x;
    cmd = c;
    dummy = dm;
    idle = il;
  endtask
  task automatic req(input logic [31:0] a);
    int i;
    @(posedge core_clk_i);
    #1 req_valid_i = 1'b1;
    req_addr_i = a;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk_i);
      if (req_ready_o === 1'b1) break;
    end
    #1 req_valid_i = 1'b0;
    check(i < 3000, 1'b1);
  endtask
  task automatic get_word(input logic [31:0] a);
    int i, k;
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 3000; i++) begin
        @(posedge core_clk_i);
        if (rd_valid_o === 1'b1) break;
      end
      check({24'h0, rd_data_o}, fb(a + k));
    end
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk_i);
      if (busy_o === 1'b0) break;
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst_b_i, req_valid_i, req_addr_i, fill, j} = '0;
    rd_ready_i = 1'b1;
    {dly, rate, div, rxph, quad, a4, cmd, dummy, idle} = {3'h7, 8'h00, 2'h3, 3'h0, 8'h03, 5'h00, 8'haa};
    repeat (8) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
    // Single-line setup at rate 0 with the largest divider (half period 4), longest delays, hold-last idle
    cfg(3'h7, 8'h00, 2'h3, 1'b0, 1'b0, 1'b0, 8'h03, 5'h00, 8'haa);
    req(32'h0000_0101);
    get_word(32'h0000_0101);
    check(fl_cmd, 8'h03);
    wait_idle();
    check({dq_oe[0], dq_o[0]}, 2'h3);
    $display("test slow single done");
    // Shortest delays; fill the buffer until requests stall
    cfg(3'h0, 8'h02, 2'h0, 1'b0, 1'b0, 1'b0, 8'h03, 5'h00, 8'haa);
    #1 rd_ready_i = 1'b0;
    for (j = 0; j < 4; j++) req(32'h0000_0200 + 4 * j);
    wait_idle();
    #1 req_valid_i = 1'b1;
    repeat (8) @(posedge core_clk_i);
    check(req_ready_o, 1'b0);
    #1 req_valid_i = 1'b0;
    rd_ready_i = 1'b1;
    for (j = 0; j < 4; j++) get_word(32'h0000_0200 + 4 * j);
    req(32'h0000_0210);
    get_word(32'h0000_0210);
    wait_idle();
    $display("test buffer fill done");
    // Quad width, 4-byte address, late receive sampling, idle floating on lines 0-1, driven low/high on lines 2/3
    cfg(3'h0, 8'h01, 2'h0, 1'b1, 1'b1, 1'b1, 8'hec, 5'h06, {2'h1, 2'h0, 2'h3, 2'h3});
    req(32'h1234_5678);
    get_word(32'h1234_5678);
    check(fl_cmd, 8'hec);
    wait_idle();
    repeat (2) @(posedge core_clk_i);
    check(dq_oe, 4'hc);
    check(dq_o[3:2], 2'h2);
    $display("test quad done");
    summarize();
  end
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
